// ==== logic/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // pins in, synchronised out
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      meta_q <= '0;
      pin_sync_out <= '0;
    end else begin
      meta_q <= pin_in;
      pin_sync_out <= meta_q;
    end
  end
endmodule : pin_sync

// ==== logic/spi_clk_gen.sv ====
`timescale 1ns/1ps
module spi_clk_gen import spi_host_pkg::*; #(
  parameter int CNT_W = 10
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic [2:0] rate,
  // one pulse per half period
  output logic half_tick
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] half_len;

  // half period doubles per rate step, rate 0 is the fastest
  assign half_len = CNT_W'(SCK_MIN_HALF_CYC) << rate;

  always_ff @(posedge sys_clk) begin
    if (!rst_b || !run) begin
      cnt_q <= '0;
      half_tick <= 1'b0;
    end else if (cnt_q == half_len - CNT_W'(1)) begin
      cnt_q <= '0;
      half_tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
      half_tick <= 1'b0;
    end
  end
endmodule : spi_clk_gen

// ==== logic/spi_host.sv ====
`timescale 1ns/1ps
module spi_host import spi_host_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [DATA_W-1:0] rdata,
  // serial clock pin
  output logic sck_o,
  output logic sck_oe_b,
  input wire logic sck_i,
  // data pins
  output logic mosi_o,
  output logic mosi_oe_b,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_b,
  input wire logic miso_i,
  // device slave select pin
  output logic ss_n_o
);
  logic [DATA_W-1:0] ctrl_q;
  logic [DATA_W-1:0] sel_q;
  logic [DATA_W-1:0] tx_q;
  logic [DATA_W-1:0] rx_q;
  logic [DATA_W-1:0] data_q;
  logic [3:0] edge_cnt_q;
  logic done_q;
  logic ovr_q;
  logic coll_q;
  logic sck_prev_q;
  mst_state_t state_q;
  logic [2:0] pins_s;
  logic sck_s;
  logic mosi_s;
  logic miso_s;
  logic half_tick;
  logic en;
  logic host_master;
  logic clock_polarity;
  logic clock_phase;
  logic simplex;
  logic drive_ok;
  logic busy;
  logic edge_ev;
  logic sample_now;
  logic rx_bit;
  logic [DATA_W-1:0] rx_next;
  logic last_edge;
  logic complete;
  logic wr_ctrl;
  logic wr_sel;
  logic wr_data;
  logic rd_data;
  logic rd_stat;
  logic start;
  logic load_slave;

  pin_sync #(.W(3)) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pin_in({sck_i, mosi_i, miso_i}),
    .pin_sync_out(pins_s)
  );
  assign {sck_s, mosi_s, miso_s} = pins_s;

  spi_clk_gen u_clk (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .run(state_q != ST_IDLE),
    .rate(ctrl_q[CTRL_RATE_LO +: 3]),
    .half_tick(half_tick)
  );

  assign en = ctrl_q[CTRL_EN];
  assign host_master = ctrl_q[CTRL_MASTER];
  assign clock_polarity = ctrl_q[CTRL_CLOCK_POLARITY];
  assign clock_phase = ctrl_q[CTRL_CLOCK_PHASE];
  assign simplex = ctrl_q[CTRL_SIMPLEX];
  assign drive_ok = !simplex || sel_q[SEL_DRIVE];

  assign wr_ctrl = wr_stb && addr == REG_CTRL;
  assign wr_sel = wr_stb && addr == REG_SEL;
  assign wr_data = wr_stb && addr == REG_DATA;
  assign rd_data = rd_stb && addr == REG_DATA;
  assign rd_stat = rd_stb && addr == REG_STAT;

  assign busy = host_master ? (state_q != ST_IDLE) : (edge_cnt_q != 4'h0);
  // only an enabled master starts a byte
  assign start = wr_data && en && host_master && !busy;
  assign load_slave = wr_data && !host_master && !busy;

  // master edges come from the divider, slave edges from the sampled clock pin
  assign edge_ev = host_master ? (half_tick && state_q == ST_SHIFT)
                               : (en && sck_s != sck_prev_q);
  assign sample_now = is_sample_edge(edge_cnt_q[0], clock_phase);
  assign rx_bit = (host_master && !simplex) ? miso_s : mosi_s;
  assign rx_next = sample_now ? {rx_q[DATA_W-2:0], rx_bit} : rx_q;
  assign last_edge = edge_cnt_q == 4'(EDGES_PER_BYTE - 1);
  assign complete = edge_ev && last_edge;

  // control registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= wdata;
      if (wdata[CTRL_RATE_LO +: 3] > RATE_MAX) begin
        ctrl_q[CTRL_RATE_LO +: 3] <= RATE_MAX;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sel_q <= SEL_RST;
    end else if (wr_sel) begin
      sel_q <= wdata;
    end
  end

  // master sequencer
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !en || !host_master) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (half_tick) begin
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (edge_ev && last_edge) begin
            state_q <= ST_TRAIL;
          end
        end
        ST_TRAIL: begin
          if (half_tick) begin
            state_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (half_tick) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // edge counter, cleared whenever framing is lost
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !en || (host_master && state_q == ST_IDLE)) begin
      edge_cnt_q <= 4'h0;
    end else if (edge_ev) begin
      edge_cnt_q <= edge_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
    end
  end

  // transmit shifter, msb first, first bit ready before the first edge
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx_q <= '0;
    end else if (start || load_slave) begin
      tx_q <= wdata;
    end else if (edge_ev && !sample_now && edge_cnt_q != 4'h0) begin
      tx_q <= {tx_q[DATA_W-2:0], 1'b0};
    end
  end

  // receive shifter shifts on the sample edges, transmit on the other edges after the first
  always_ff @(posedge sys_clk) begin
    if (!rst_b || start) begin
      rx_q <= '0;
    end else if (edge_ev) begin
      rx_q <= rx_next;
    end
  end

  // received byte; on overrun the earlier byte is kept
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      data_q <= '0;
    end else if (complete && !done_q) begin
      data_q <= rx_next;
    end
  end

  // done: set wins over the clear by a data read
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      done_q <= 1'b0;
    end else if (complete) begin
      done_q <= 1'b1;
    end else if (rd_data) begin
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ovr_q <= 1'b0;
    end else if (complete && done_q) begin
      ovr_q <= 1'b1;
    end else if (rd_stat) begin
      ovr_q <= 1'b0;
    end
  end

  // data write during a byte is dropped
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      coll_q <= 1'b0;
    end else if (wr_data && busy) begin
      coll_q <= 1'b1;
    end else if (rd_stat) begin
      coll_q <= 1'b0;
    end
  end

  // serial clock out, idle at the polarity level
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sck_o <= 1'b0;
    end else if (state_q != ST_SHIFT) begin
      sck_o <= clock_polarity;
    end else if (half_tick) begin
      sck_o <= !sck_o;
    end
  end

  // pin drivers, enable low while driving
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sck_oe_b <= 1'b1;
      mosi_oe_b <= 1'b1;
      miso_oe_b <= 1'b1;
    end else begin
      sck_oe_b <= !(en && host_master);
      mosi_oe_b <= !(en && host_master && drive_ok);
      miso_oe_b <= !(en && !host_master && drive_ok);
    end
  end

  assign mosi_o = tx_q[DATA_W-1];
  assign miso_o = tx_q[DATA_W-1];

  // device select: high around a device master; in auto mode framed around our bytes for phase 0, held low for phase 1
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ss_n_o <= 1'b1;
    end else if (!en || !host_master) begin
      ss_n_o <= 1'b1;
    end else if (!sel_q[SEL_AUTO]) begin
      ss_n_o <= sel_q[SEL_LEVEL];
    end else if (clock_phase) begin
      ss_n_o <= 1'b0;
    end else begin
      ss_n_o <= !(start || state_q == ST_LEAD || state_q == ST_SHIFT || state_q == ST_TRAIL);
    end
  end

  // read data, valid the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rdata <= '0;
    end else if (rd_stb) begin
      unique case (addr)
        REG_CTRL: rdata <= ctrl_q;
        REG_SEL: rdata <= {5'h00, sel_q[2:0]};
        REG_DATA: rdata <= data_q;
        REG_STAT: rdata <= {4'h0, coll_q, ovr_q, done_q, busy};
        default: rdata <= '0;
      endcase
    end
  end
endmodule : spi_host

// ==== shared/spi_host_pkg.sv ====
package spi_host_pkg;
  localparam int SYS_CLK_PERIOD_NS = 25;
  localparam int SCK_MIN_PERIOD_NS = 200;
  localparam int SCK_MIN_HALF_CYC = (SCK_MIN_PERIOD_NS / 2 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int EDGES_PER_BYTE = 2 * DATA_W;
  // register offsets
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_SEL = 3'h1;
  localparam logic [2:0] REG_DATA = 3'h2;
  localparam logic [2:0] REG_STAT = 3'h3;
  // control fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_MASTER = 1;
  localparam int CTRL_CLOCK_POLARITY = 2;
  localparam int CTRL_CLOCK_PHASE = 3;
  localparam int CTRL_RATE_LO = 4;
  localparam int CTRL_SIMPLEX = 7;
  localparam logic [2:0] RATE_MAX = 3'h5;
  // select fields
  localparam int SEL_LEVEL = 0;
  localparam int SEL_AUTO = 1;
  localparam int SEL_DRIVE = 2;
  // status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_OVR = 2;
  localparam int STAT_COLL = 3;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] SEL_RST = 8'h03;

  typedef enum {ST_IDLE, ST_LEAD, ST_SHIFT, ST_TRAIL, ST_GAP} mst_state_t;

  // even edges are first edges of a bit; phase picks which one samples
  function automatic logic is_sample_edge(input logic edge_odd, input logic clock_phase);
    return edge_odd == clock_phase;
  endfunction : is_sample_edge
endpackage : spi_host_pkg

// ==== test/spi_dev_model.sv ====
`timescale 1ns/1ps
module spi_dev_model (
  // mode and role
  input wire logic clock_polarity,
  input wire logic clock_phase,
  input wire logic dev_master,
  input wire logic go,
  input wire logic [7:0] tx,
  // link
  input wire logic ss_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  output logic dev_sck,
  output logic dev_out,
  // results
  output logic run,
  output logic [7:0] rx_byte
);
  logic clk_q = 1'b0;
  logic [7:0] rx = 8'h00;
  int k = 0;
  int n = 0;
  int idx;
  wire logic sel_n = dev_master ? !run : ss_n;
  assign dev_sck = run ? clk_q : clock_polarity;
  initial begin
    run = 1'b0;
    dev_out = 1'b0;
    rx_byte = 8'h00;
  end
  // own clock runs only inside a frame
  always @(posedge go) if (dev_master) begin
    clk_q = clock_polarity;
    #37 run = 1'b1;
    repeat (16) #100 clk_q = ~clk_q;
    #100 run = 1'b0;
  end
  always @(negedge sel_n) begin
    k = 0;
    n = 0;
    if (!clock_phase) dev_out = tx[7];
  end
  // released line shows the inverse
  always @(posedge sel_n) dev_out = ~dev_out;
  always @(sck) if (!sel_n) begin
    if (sck ^ clock_polarity ^ clock_phase) begin
      rx = {rx[6:0], dev_master ? miso : mosi};
      n++;
      if (n == 8) begin
        rx_byte = rx;
        n = 0;
        if (clock_phase) k = 0;
      end
    end else begin
      k++;
      idx = 7 - k + int'(clock_phase);
      dev_out = (idx >= 0 && idx < 8) ? tx[idx] : ~dev_out;
    end
  end
endmodule : spi_dev_model

// ==== test/spi_host_properties.sv ====
`timescale 1ns/1ps
module spi_host_checker import spi_host_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [DATA_W-1:0] rdata,
  // pins
  input wire logic sck_o,
  input wire logic sck_oe_b,
  input wire logic mosi_oe_b,
  input wire logic miso_oe_b,
  input wire logic ss_n_o
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_data_wr;
    wr_stb && addr == REG_DATA && !sck_oe_b;
  endsequence
  sequence s_sck_step;
    !sck_oe_b && $changed(sck_o) && !$past(wr_stb);
  endsequence
  a_one_data_drive: assert property (mosi_oe_b || miso_oe_b)
    else $error("both data lines driven");
  a_slave_ss_high: assert property (!miso_oe_b |-> ss_n_o && sck_oe_b)
    else $error("slave role drives select or clock");
  a_rdata_on_read: assert property ($changed(rdata) |-> $past(rd_stb))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (rd_stb && addr[2] |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_sck_half_min: assert property (s_sck_step |=> $stable(sck_o) [*3])
    else $error("serial clock half period too short");
  a_frame_select: assert property (s_sck_step |-> !ss_n_o)
    else $error("clock edge with device unselected");
  a_write_clocks: assert property (s_data_wr ##1 !ss_n_o |-> ##[1:600] $changed(sck_o))
    else $error("data write did not start the clock");
  a_reset_released: assert property ($rose(rst_b) |-> sck_oe_b && mosi_oe_b && miso_oe_b && ss_n_o)
    else $error("pins driven after reset");
endmodule : spi_host_checker

bind spi_host spi_host_checker u_checker (.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .sck_o(sck_o), .sck_oe_b(sck_oe_b), .mosi_oe_b(mosi_oe_b),
  .miso_oe_b(miso_oe_b), .ss_n_o(ss_n_o));

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top import spi_host_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] rdata;
  logic sck_o, sck_oe_b, mosi_o, mosi_oe_b, miso_o, miso_oe_b, ss_n_o;
  logic clock_polarity = 1'b0;
  logic clock_phase = 1'b0;
  logic dm = 1'b0;
  logic go = 1'b0;
  logic [7:0] dtx = 8'h00;
  logic dev_sck, dev_out, dm_run;
  logic [7:0] rx_dev;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int r, t0, t1, i;
  logic [1:0] m;
  logic [7:0] v;
  wire logic sck_w = sck_oe_b ? dev_sck : sck_o;
  wire logic mosi_w = mosi_oe_b ? dev_out : mosi_o;
  wire logic miso_w = miso_oe_b ? dev_out : miso_o;

  spi_host DUT (.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .sck_o(sck_o), .sck_oe_b(sck_oe_b), .sck_i(sck_w), .mosi_o(mosi_o),
    .mosi_oe_b(mosi_oe_b), .mosi_i(mosi_w), .miso_o(miso_o), .miso_oe_b(miso_oe_b), .miso_i(miso_w),
    .ss_n_o(ss_n_o));
  spi_dev_model u_dev (.clock_polarity(clock_polarity), .clock_phase(clock_phase), .dev_master(dm), .go(go), .tx(dtx), .ss_n(ss_n_o),
    .sck(sck_w), .mosi(mosi_w), .miso(miso_w), .dev_sck(dev_sck), .dev_out(dev_out), .run(dm_run),
    .rx_byte(rx_dev));

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;

  task automatic conclude();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic wait_idle(output logic [7:0] s);
    int j;
    s = 8'h01;
    for (j = 0; j < 3000 && s[0] !== 1'b0; j++) rd(REG_STAT, s);
    if (s[0] !== 1'b0) begin
      errors++;
      conclude();
    end
  endtask : wait_idle
  task automatic wait_sck(output int t);
    logic s;
    int j;
    s = sck_o;
    for (j = 0; j < 400 && sck_o === s; j++) @(posedge sys_clk);
    if (sck_o === s) begin
      errors++;
      conclude();
    end
    t = cyc;
  endtask : wait_sck
  task automatic dev_frame();
    int j;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    for (j = 0; j < 200 && (j < 4 || dm_run); j++) @(posedge sys_clk);
    if (dm_run) begin
      errors++;
      conclude();
    end
    // allow for the pin synchronisers
    repeat (6) @(posedge sys_clk);
  endtask : dev_frame

  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(REG_CTRL, v);
    chk(v, CTRL_RST);
    rd(REG_SEL, v);
    chk(v, SEL_RST);
    rd(REG_STAT, v);
    chk(v, 8'h00);
    for (i = 4; i < 8; i++) begin
      wr(3'(i), 8'hFF);
      rd(3'(i), v);
      chk(v, 8'h00);
    end
    wr(REG_SEL, 8'h02);
    for (r = 0; r < 6; r++) begin
      m = 2'(r % 4);
      clock_polarity <= m[0];
      clock_phase <= m[1];
      dtx <= 8'hA5 ^ 8'(r);
      // new polarity taken while pins are released, so enabling makes no clock edge
      wr(REG_CTRL, {4'h0, m[1], m[0], 2'b00});
      wr(REG_CTRL, {1'b0, 3'(r), m[1], m[0], 2'b11});
      wr(REG_DATA, 8'h3C + 8'(r));
      wait_sck(t0);
      wait_sck(t1);
      chk(8'(t1 - t0), 8'(4 << r));
      if (r == 1) begin
        wr(REG_DATA, 8'hEE);
        rd(REG_STAT, v);
        chk(v, 8'h09);
      end
      wait_idle(v);
      chk(v, 8'h02);
      chk({7'h00, ss_n_o}, {7'h00, ~m[1]});
      chk(rx_dev, 8'h3C + 8'(r));
      rd(REG_DATA, v);
      chk(v, 8'hA5 ^ 8'(r));
      rd(REG_STAT, v);
      chk(v, 8'h00);
    end
    dm <= 1'b1;
    clock_polarity <= 1'b0;
    clock_phase <= 1'b0;
    wr(REG_CTRL, 8'h00);
    // released clock pin must pass the synchronisers before the edge detector is enabled
    repeat (4) @(posedge sys_clk);
    wr(REG_CTRL, 8'h01);
    wr(REG_DATA, 8'h96);
    dtx <= 8'h5A;
    dev_frame();
    chk(rx_dev, 8'h96);
    rd(REG_STAT, v);
    chk(v & 8'h0E, 8'h02);
    chk({7'h00, ss_n_o}, 8'h01);
    dtx <= 8'hC3;
    dev_frame();
    rd(REG_STAT, v);
    chk(v & 8'h0E, 8'h06);
    rd(REG_DATA, v);
    chk(v, 8'h5A);
    rd(REG_STAT, v);
    chk(v & 8'h0E, 8'h00);
    conclude();
  end
endmodule : tb_top
